// ### rtl/mcs_memory_checksum_scanner.sv
// memory checksum scanner: flash section checksum, startup check, fatal interrupt
`timescale 1ns/10ps
`default_nettype none
`include "mcs_scanner_cfg.svh"

module mcs_memory_checksum_scanner
    import mcs_pkg::*;
#(
    parameter int FA_W = 15,
    parameter logic [14:0] LAST_FLASH_ADDRESS = 15'h7fff,
    parameter int FETCH_PERIOD = `MCS_FETCH_PERIOD,
    parameter int STARTUP_FETCH_PERIOD = `MCS_STARTUP_FETCH_PERIOD
) (
    input wire logic i_clk, // main clock, 10 mhz
    input wire logic i_rst_b, // system reset, async, active low
    input wire logic i_wb_cyc, // wishbone cycle
    input wire logic i_wb_stb, // wishbone strobe
    input wire logic i_wb_we, // wishbone write
    input wire logic [3:0] i_wb_adr, // wishbone byte address
    input wire logic [3:0] i_wb_sel, // wishbone byte lanes
    input wire logic [31:0] i_wb_dat, // wishbone write data
    input wire logic i_wb_dbg, // current request comes from the debugger
    output logic [31:0] o_wb_dat, // wishbone read data
    output logic o_wb_ack, // wishbone acknowledge
    input wire logic i_dbg_mem_access, // debugger touching peripheral or memory
    input wire logic i_dbg_ireg_access, // debugger internal register access
    input wire logic i_dbg_connected, // debugger attached
    output logic [1:0] o_dbg_status, // synchronised {pass, busy} copy
    input wire logic i_cpu_sleep, // cpu in any sleep mode
    input wire logic [1:0] i_startup_scan_fuse_field, // startup scan section
    input wire logic [7:0] i_loader_end_fuse, // loader end, 256-byte units
    input wire logic [7:0] i_app_end_fuse, // application end, 256-byte units
    output logic o_flash_rd, // flash word read request
    output logic [FA_W-2:0] o_flash_addr, // flash word address
    input wire logic [15:0] i_flash_rdata, // word, valid cycle after request
    output logic o_cpu_stall, // scanner holds flash, cpu waits
    output logic o_cpu_run, // cpu may leave reset initialisation
    output logic o_irq_defer, // hold off interrupt handlers
    output logic o_fatal_irq // non-maskable interrupt request
);

    ////////////////////////////////////////////////////////////////////////////
    // pins and section decode

    logic [2:0] dbg_lvl;
    logic [2:0] dbg_prev_q;

    mcs_pin_sync #(.W(3)) u_dbg_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pin({i_dbg_connected, i_dbg_ireg_access, i_dbg_mem_access}),
        .o_level(dbg_lvl)
    );

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dbg_prev_q <= 3'h0;
        end else begin
            dbg_prev_q <= dbg_lvl;
        end
    end

    logic dbg_take;
    logic dbg_give;
    assign dbg_take = dbg_lvl[0] & ~dbg_prev_q[0];
    // internal register access or disconnect hands the flash back
    assign dbg_give = (dbg_lvl[1] & ~dbg_prev_q[1]) | (~dbg_lvl[2] & dbg_prev_q[2]);

    function automatic logic [FA_W-1:0] last_byte(input logic [1:0] sel);
        logic [15:0] end_addr;
        end_addr = 16'hffff;
        unique case (sel)
            MCS_SEC_LOADER_PLUS_APP: end_addr = {i_app_end_fuse - 8'h01, 8'hff};
            MCS_SEC_LOADER: end_addr = {i_loader_end_fuse - 8'h01, 8'hff};
            default: end_addr = 16'(LAST_FLASH_ADDRESS);
        endcase
        return end_addr[FA_W-1:0];
    endfunction : last_byte

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    logic req;
    logic wr;
    logic [1:0] idx;
    logic mapped;
    logic wr_ok;
    logic wr_a;
    logic wr_b;
    logic wr_s;
    logic [7:0] wd;

    logic enable_q;
    logic fatal_irq_enable_q;
    logic [1:0] scan_section_select_q;
    logic pass_q;
    logic fatal_irq_q;
    logic soft_rst_q;
    logic busy;
    logic pass_rd;
    mcs_state_t state_q;

    assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr = req & i_wb_we & i_wb_sel[0];
    assign idx = i_wb_adr[3:2];
    assign mapped = idx != 2'h3;
    assign wd = i_wb_dat[7:0];
    // once the fatal interrupt fired every register write is ignored
    assign wr_ok = wr & ~fatal_irq_q;
    assign wr_a = wr_ok & (idx == `MCS_IDX_CONTROL_REG_A);
    assign wr_b = wr_ok & (idx == `MCS_IDX_CONTROL_REG_B);
    assign wr_s = wr_ok & (idx == `MCS_IDX_STATUS) & i_wb_dbg;
    assign busy = state_q != MCS_ST_IDLE;
    assign pass_rd = pass_q & ~busy;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= 32'h0;
            if (req && !i_wb_we && mapped) begin
                unique case (idx)
                    `MCS_IDX_CONTROL_REG_A: begin
                        o_wb_dat[`MCS_CONTROL_REG_A_ENABLE] <= enable_q;
                        o_wb_dat[`MCS_CONTROL_REG_A_FATAL_IRQ_ENABLE] <= fatal_irq_enable_q;
                    end
                    `MCS_IDX_CONTROL_REG_B: begin
                        o_wb_dat[`MCS_CONTROL_REG_B_SEL_MSB:`MCS_CONTROL_REG_B_SEL_LSB] <= scan_section_select_q;
                    end
                    default: begin
                        o_wb_dat[`MCS_STAT_BUSY] <= busy;
                        o_wb_dat[`MCS_STAT_PASS] <= pass_rd;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start requests

    logic boot_pend_q;
    logic boot_scan_q;
    logic boot_go;
    logic sw_go;
    logic dbg_start_q;
    logic dbg_go;
    logic dbg_cancel;
    logic block_q;
    logic go;
    logic soft_rst_req;

    // strap caught on the first edge after release, not under reset
    assign boot_go = boot_pend_q & (i_startup_scan_fuse_field != `MCS_FUSE_NO_SCAN);
    assign sw_go = wr_a & wd[`MCS_CONTROL_REG_A_ENABLE];
    assign dbg_cancel = wr_s & ~wd[`MCS_STAT_BUSY];
    assign dbg_go = dbg_start_q & ~block_q & ~busy;
    assign go = boot_go | sw_go | dbg_go;
    // with fatal enable set the soft reset cannot abort a running check
    assign soft_rst_req = wr_a & wd[`MCS_CONTROL_REG_A_SOFT_RESET] & ~(fatal_irq_enable_q & busy);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_pend_q <= 1'b1;
            boot_scan_q <= 1'b0;
        end else begin
            boot_pend_q <= 1'b0;
            if (boot_go) begin
                boot_scan_q <= 1'b1;
            end else if (!busy) begin
                boot_scan_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dbg_start_q <= 1'b0;
        end else if (wr_s && wd[`MCS_STAT_BUSY]) begin
            dbg_start_q <= 1'b1;
        end else if (dbg_go || dbg_cancel) begin
            dbg_start_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            block_q <= 1'b0;
        end else if (dbg_take) begin
            block_q <= 1'b1;
        end else if (dbg_give) begin
            block_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= soft_rst_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_q <= 1'(`MCS_RST_CONTROL_REG_A >> `MCS_CONTROL_REG_A_ENABLE);
        end else if (soft_rst_q) begin
            enable_q <= 1'b0;
        end else if (boot_go) begin
            enable_q <= 1'b1;
        end else if (wr_a) begin
            // clearing only stops after the running check ends
            enable_q <= wd[`MCS_CONTROL_REG_A_ENABLE];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fatal_irq_enable_q <= 1'b0;
        end else if (wr_a && wd[`MCS_CONTROL_REG_A_FATAL_IRQ_ENABLE] && !busy) begin
            fatal_irq_enable_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scan_section_select_q <= 2'(`MCS_RST_CONTROL_REG_B);
        end else if (soft_rst_q) begin
            scan_section_select_q <= 2'(`MCS_RST_CONTROL_REG_B);
        end else if (boot_go) begin
            scan_section_select_q <= i_startup_scan_fuse_field;
        end else if (wr_b && !busy) begin
            scan_section_select_q <= wd[`MCS_CONTROL_REG_B_SEL_MSB:`MCS_CONTROL_REG_B_SEL_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan sequencer

    logic [1:0] dly_q;
    logic [3:0] pace_q;
    logic [FA_W-2:0] word_q;
    logic [FA_W-2:0] last_word_q;
    logic issued_all_q;
    logic rd_last_q;
    logic vld_q;
    logic vld_last_q;
    logic [15:0] crc_q;
    logic done;
    logic match;
    logic [3:0] period;
    logic [15:0] stored;
    logic [FA_W-1:0] last_sel;

    mcs_crc_if crc_bus ();
    mcs_crc16 u_crc (
        .bus(crc_bus.engine)
    );

    assign crc_bus.crc_in = crc_q;
    assign crc_bus.word = i_flash_rdata;
    // high checksum byte is the even address, so it is the low half
    assign stored = {i_flash_rdata[7:0], i_flash_rdata[15:8]};
    assign match = crc_q == stored;
    assign done = (state_q == MCS_ST_SCAN) && vld_q && vld_last_q;
    assign period = boot_scan_q ? 4'(STARTUP_FETCH_PERIOD) : 4'(FETCH_PERIOD);
    assign last_sel = last_byte(boot_go ? i_startup_scan_fuse_field : scan_section_select_q);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= MCS_ST_IDLE;
            dly_q <= 2'h0;
            pace_q <= 4'h0;
            word_q <= '0;
            last_word_q <= '0;
            issued_all_q <= 1'b0;
            o_flash_rd <= 1'b0;
            o_flash_addr <= '0;
            rd_last_q <= 1'b0;
            vld_q <= 1'b0;
            vld_last_q <= 1'b0;
            crc_q <= `MCS_CRC_INIT;
        end else begin
            o_flash_rd <= 1'b0;
            vld_q <= o_flash_rd;
            vld_last_q <= rd_last_q;
            if (soft_rst_q || dbg_cancel) begin
                state_q <= MCS_ST_IDLE;
                vld_q <= 1'b0;
            end else if (go) begin
                state_q <= MCS_ST_START;
                dly_q <= 2'h0;
                vld_q <= 1'b0;
                last_word_q <= last_sel[FA_W-1:1];
            end else begin
                unique case (state_q)
                    MCS_ST_IDLE: begin
                    end
                    MCS_ST_START: begin
                        if (block_q) begin
                            state_q <= MCS_ST_HOLD;
                        end else if (!i_cpu_sleep) begin
                            dly_q <= dly_q + 2'h1;
                            if (dly_q == 2'(`MCS_START_DELAY - 1)) begin
                                state_q <= MCS_ST_SCAN;
                                crc_q <= `MCS_CRC_INIT;
                                word_q <= '0;
                                pace_q <= 4'h0;
                                issued_all_q <= 1'b0;
                            end
                        end
                    end
                    MCS_ST_SCAN: begin
                        if (block_q) begin
                            state_q <= MCS_ST_HOLD;
                            vld_q <= 1'b0;
                        end else begin
                            if (!i_cpu_sleep) begin
                                pace_q <= (pace_q == period - 4'h1) ? 4'h0 : pace_q + 4'h1;
                                if (pace_q == 4'h0 && !issued_all_q) begin
                                    o_flash_rd <= 1'b1;
                                    o_flash_addr <= word_q;
                                    rd_last_q <= word_q == last_word_q;
                                    issued_all_q <= word_q == last_word_q;
                                    word_q <= word_q + 1'b1;
                                end
                            end
                            if (vld_q && !vld_last_q) begin
                                crc_q <= crc_bus.crc_out;
                            end
                            if (done) begin
                                state_q <= MCS_ST_IDLE;
                            end
                        end
                    end
                    MCS_ST_HOLD: begin
                        // the interrupted check starts over from byte zero
                        if (!block_q) begin
                            state_q <= MCS_ST_START;
                            dly_q <= 2'h0;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status, fatal interrupt and cpu control

    logic pass_clear;
    assign pass_clear = (done && !match) || (wr_s && !wd[`MCS_STAT_PASS]);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pass_q <= 1'(`MCS_RST_STATUS >> `MCS_STAT_PASS);
        end else if (done) begin
            // completion outranks a write landing in the same cycle
            pass_q <= match;
        end else if (go) begin
            pass_q <= 1'b0;
        end else if (soft_rst_q) begin
            pass_q <= 1'b1;
        end else if (wr_s) begin
            pass_q <= wd[`MCS_STAT_PASS];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fatal_irq <= 1'b0;
        end else if (pass_clear && fatal_irq_enable_q) begin
            o_fatal_irq <= 1'b1;
        end
    end
    assign fatal_irq_q = o_fatal_irq;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cpu_run <= 1'b0;
        end else if (boot_pend_q && !boot_go) begin
            o_cpu_run <= 1'b1;
        end else if (done && boot_scan_q && match) begin
            o_cpu_run <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dbg_status <= 2'h0;
        end else begin
            o_dbg_status <= {pass_rd, busy};
        end
    end

    assign o_cpu_stall = state_q == MCS_ST_SCAN;
    assign o_irq_defer = busy;

endmodule : mcs_memory_checksum_scanner

`default_nettype wire

// ### rtl/mcs_scanner_cfg.svh
// constants for the memory checksum scanner: offsets, fields, resets, timing
`ifndef MCS_SCANNER_CFG_SVH
`define MCS_SCANNER_CFG_SVH

// register indices; byte address on the bus is four times the index
`define MCS_IDX_CONTROL_REG_A 2'h0
`define MCS_IDX_CONTROL_REG_B 2'h1
`define MCS_IDX_STATUS 2'h2

// control_reg_a fields
`define MCS_CONTROL_REG_A_ENABLE 0
`define MCS_CONTROL_REG_A_FATAL_IRQ_ENABLE 1
`define MCS_CONTROL_REG_A_SOFT_RESET 7

// control_reg_b field
`define MCS_CONTROL_REG_B_SEL_LSB 0
`define MCS_CONTROL_REG_B_SEL_MSB 1

// status fields
`define MCS_STAT_BUSY 0
`define MCS_STAT_PASS 1

// reset values
`define MCS_RST_CONTROL_REG_A 8'h00
`define MCS_RST_CONTROL_REG_B 8'h00
`define MCS_RST_STATUS 8'h02

// checksum engine
`define MCS_CRC_INIT 16'hffff
`define MCS_CRC_POLY 16'h1021

// timing, in main clock cycles
`define MCS_START_DELAY 3
`define MCS_FETCH_PERIOD 3
`define MCS_STARTUP_FETCH_PERIOD 1

// startup fuse field code that means no scan before the cpu starts
`define MCS_FUSE_NO_SCAN 2'h3

`endif

// ### rtl/mcs_pkg.sv
// types shared by the memory checksum scanner modules
package mcs_pkg;

    typedef enum logic [1:0] {
        MCS_SEC_FLASH = 2'h0,
        MCS_SEC_LOADER_PLUS_APP = 2'h1,
        MCS_SEC_LOADER = 2'h2,
        MCS_SEC_RESERVED = 2'h3
    } mcs_section_t;

    typedef enum logic [1:0] {
        MCS_ST_IDLE,
        MCS_ST_START,
        MCS_ST_SCAN,
        MCS_ST_HOLD
    } mcs_state_t;

endpackage : mcs_pkg

// ### rtl/mcs_crc_if.sv
// carrier between the scanner and its checksum engine
`timescale 1ns/10ps
`default_nettype none

interface mcs_crc_if;
    logic [15:0] crc_in;
    logic [15:0] word;
    logic [15:0] crc_out;
    modport user (output crc_in, output word, input crc_out);
    modport engine (input crc_in, input word, output crc_out);
endinterface : mcs_crc_if

`default_nettype wire

// ### rtl/mcs_crc16.sv
// checksum engine: one flash word, low byte then high byte, msb first
`timescale 1ns/10ps
`default_nettype none
`include "mcs_scanner_cfg.svh"

module mcs_crc16 (
    mcs_crc_if.engine bus // running value, word in, updated value out
);

    function automatic logic [15:0] mcs_crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ b[i]) begin
                r = {r[14:0], 1'b0} ^ `MCS_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : mcs_crc_byte

    // the even byte address sits in the low half of a word
    assign bus.crc_out = mcs_crc_byte(mcs_crc_byte(bus.crc_in, bus.word[7:0]), bus.word[15:8]);

endmodule : mcs_crc16

`default_nettype wire

// ### rtl/mcs_pin_sync.sv
// three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module mcs_pin_sync #(
    parameter int W = 1
) (
    input wire logic i_clk, // main clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic [W-1:0] i_pin, // asynchronous pins
    output var logic [W-1:0] o_level // filtered level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_level <= '0;
        end else begin
            o_level <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & o_level);
        end
    end

endmodule : mcs_pin_sync

`default_nettype wire

// ### sim/mcs_scanner_asserts.sv
// port assertions for the memory checksum scanner
`timescale 1ns/10ps
`default_nettype none
module mcs_scanner_asserts (
    input wire logic i_clk, // main clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic i_wb_cyc, // bus cycle
    input wire logic i_wb_stb, // bus strobe
    input wire logic o_wb_ack, // bus acknowledge
    input wire logic i_cpu_sleep, // cpu sleeping
    input wire logic o_flash_rd, // flash read pulse
    input wire logic o_cpu_stall, // cpu stalled
    input wire logic o_cpu_run, // cpu may run
    input wire logic o_irq_defer, // busy view
    input wire logic o_fatal_irq // fatal request
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_ack_follow: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing");
    chk_fatal_hold: assert property (o_fatal_irq |=> o_fatal_irq)
        else $error("fatal request dropped");
    chk_run_hold: assert property (o_cpu_run |=> o_cpu_run)
        else $error("cpu run dropped");
    chk_rd_pacing: assert property (o_flash_rd && o_cpu_run |=> !o_flash_rd [*2])
        else $error("fetch faster than every third cycle");
    chk_rd_stalls: assert property (o_flash_rd |-> o_cpu_stall)
        else $error("fetch without cpu stall");
    chk_stall_busy: assert property (o_cpu_stall |-> o_irq_defer)
        else $error("stall while not busy");
    chk_start_delay: assert property ($rose(o_cpu_stall) |-> $past(o_irq_defer, 2))
        else $error("scan began without start delay");
    chk_sleep_pause: assert property (i_cpu_sleep && $past(i_cpu_sleep) |-> !o_flash_rd)
        else $error("fetch during sleep");
    chk_fail_done: assert property ($rose(o_fatal_irq) |-> !o_irq_defer)
        else $error("fatal raised while busy");
    cover property (o_fatal_irq);
    cover property ($rose(o_cpu_run));
    cover property (o_cpu_stall && o_cpu_run);
endmodule : mcs_scanner_asserts
`default_nettype wire

// ### sim/mcs_flash_model.sv
// flash model: 64 bytes with a valid checksum in the last two
`timescale 1ns/10ps
`default_nettype none
module mcs_flash_model (
    input wire logic i_clk, // main clock
    input wire logic i_rd, // read request
    input wire logic [13:0] i_addr, // word address
    input wire logic i_corrupt, // flip one data bit
    output logic [15:0] o_rdata // word, valid cycle after request
);
    logic [7:0] mem [64];
    logic [15:0] crc;
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc_byte
    initial begin
        o_rdata = 16'h0000;
        crc = 16'hffff;
        for (int i = 0; i < 62; i++) begin
            mem[i] = 8'(i * 7 + 3);
            crc = crc_byte(crc, mem[i]);
        end
        mem[62] = crc[15:8];
        mem[63] = crc[7:0];
    end
    // outside a reply the data bus toggles so stale data cannot pass
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_rdata <= {mem[{i_addr[4:0], 1'b1}], mem[{i_addr[4:0], 1'b0}] ^ {7'h00, i_corrupt}};
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule : mcs_flash_model
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the memory checksum scanner
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mcs_pkg::*;
    logic i_clk, i_rst_b, cyc, stb, we, sleep, mem_acc, ireg_acc, corrupt, dbg;
    logic [3:0] adr;
    logic [7:0] dat;
    logic [1:0] fuse, dstat;
    logic [31:0] rdat;
    logic ack, frd, stall, run, defer, fatal;
    logic [13:0] faddr;
    logic [15:0] fdata;
    logic [7:0] expq[$];
    int fails, check_count, seed, n;
    mcs_memory_checksum_scanner #(.LAST_FLASH_ADDRESS(15'h003f)) u_dut (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'h1), .i_wb_dat({24'h000000, dat}), .i_wb_dbg(dbg), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_dbg_mem_access(mem_acc), .i_dbg_ireg_access(ireg_acc),
        .i_dbg_connected(1'b1), .o_dbg_status(dstat), .i_cpu_sleep(sleep),
        .i_startup_scan_fuse_field(fuse), .i_loader_end_fuse(8'h00), .i_app_end_fuse(8'h00),
        .o_flash_rd(frd), .o_flash_addr(faddr), .i_flash_rdata(fdata), .o_cpu_stall(stall),
        .o_cpu_run(run), .o_irq_defer(defer), .o_fatal_irq(fatal));
    mcs_flash_model u_flash (.i_clk(i_clk), .i_rd(frd), .i_addr(faddr), .i_corrupt(corrupt),
        .o_rdata(fdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // one classic cycle; a read notes its expected byte for the monitor
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        if (!w) expq.push_back(d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= w ? d : 8'h00;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
        if (n >= 50) begin
            fails++;
            final_report();
        end
    endtask : wb
    task automatic wait_idle();
        n = 0;
        while (defer !== 1'b0 && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            final_report();
        end
    endtask : wait_idle
    always @(posedge i_clk) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) chk(rdat[7:0], expq.pop_front());
    end
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_b, cyc, stb, we, sleep, mem_acc, ireg_acc, corrupt, dbg} = 9'h000;
        {adr, dat, fuse} = 14'h0000;
        {fails, check_count} = 0;
        seed = 82515;
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int k = 0; k < 3000 && run !== 1'b1; k++) @(posedge i_clk);
        chk({7'h00, run}, 8'h01);
        wb(0, 4'h0, 8'h01);
        wb(0, 4'h4, 8'h00);
        wb(0, 4'h8, 8'h02);
        wb(1, 4'hc, 8'($random(seed)));
        wb(0, 4'hc, 8'h00);
        wb(1, 4'h0, 8'h01);
        sleep <= 1'b1;
        repeat (20) @(posedge i_clk);
        wb(0, 4'h8, 8'h01);
        sleep <= 1'b0;
        wait_idle();
        wb(0, 4'h8, 8'h02);
        chk({6'h00, dstat}, 8'h02);
        wb(1, 4'h0, 8'h01);
        wb(1, 4'h4, 8'h02);
        wb(0, 4'h4, 8'h00);
        mem_acc <= 1'b1;
        repeat (20) @(posedge i_clk);
        wb(0, 4'h8, 8'h01);
        chk({6'h00, dstat}, 8'h01);
        mem_acc <= 1'b0;
        ireg_acc <= 1'b1;
        wait_idle();
        wb(0, 4'h8, 8'h02);
        wb(1, 4'h0, 8'h01);
        // debugger status writes: cancel, then start one check
        dbg <= 1'b1;
        wb(1, 4'h8, 8'h00);
        wb(0, 4'h8, 8'h00);
        wb(1, 4'h8, 8'h03);
        dbg <= 1'b0;
        wait_idle();
        wb(0, 4'h8, 8'h02);
        wb(1, 4'h0, 8'h02);
        corrupt <= 1'b1;
        wb(1, 4'h0, 8'h03);
        wait_idle();
        wb(0, 4'h8, 8'h00);
        chk({7'h00, fatal}, 8'h01);
        wb(1, 4'h4, 8'h01);
        wb(0, 4'h4, 8'h00);
        wb(0, 4'h0, 8'h03);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (300) @(posedge i_clk);
        chk({6'h00, run, fatal}, 8'h00);
        final_report();
    end
endmodule : testbench
bind mcs_memory_checksum_scanner mcs_scanner_asserts u_chk (.i_clk, .i_rst_b, .i_wb_cyc,
    .i_wb_stb, .o_wb_ack, .i_cpu_sleep, .o_flash_rd, .o_cpu_stall, .o_cpu_run, .o_irq_defer,
    .o_fatal_irq);
`default_nettype wire
